// [common/stq_pkg.sv]
// stq_pkg: register map, reset values and encodings of the drive parameter block.
// assumes a plain register port with word indices as addresses.
package stq_pkg;
  // register indices
  localparam logic [15:0] ADDR_LS_KP = 16'h0600;
  localparam logic [15:0] ADDR_LS_TI = 16'h0601;
  localparam logic [15:0] ADDR_HS_KP = 16'h0602;
  localparam logic [15:0] ADDR_HS_TI = 16'h0603;
  localparam logic [15:0] ADDR_SW_F1 = 16'h0604;
  localparam logic [15:0] ADDR_SW_F2 = 16'h0605;
  localparam logic [15:0] ADDR_LOCK = 16'h060A;
  localparam logic [15:0] ADDR_MOT_SRC = 16'h060B;
  localparam logic [15:0] ADDR_MOT_LIM = 16'h060C;
  localparam logic [15:0] ADDR_GEN_SRC = 16'h060D;
  localparam logic [15:0] ADDR_GEN_LIM = 16'h060E;
  localparam logic [15:0] ADDR_EX_KP = 16'h0700;
  localparam logic [15:0] ADDR_EX_KI = 16'h0701;
  localparam logic [15:0] ADDR_TQ_KP = 16'h0702;
  localparam logic [15:0] ADDR_TQ_KI = 16'h0703;
  localparam logic [15:0] ADDR_OC_EN = 16'h0D00;
  localparam logic [15:0] ADDR_OC_THR = 16'h0D01;
  localparam logic [15:0] ADDR_OC_GAIN = 16'h0D02;
  localparam logic [15:0] ADDR_OC_COMP = 16'h0D03;
  localparam logic [15:0] ADDR_PCL_EN = 16'h0D04;
  localparam logic [15:0] ADDR_STATUS = 16'h0E00;
  // reset values (time 0.01 s, freq 0.01 Hz, percent 0.1 %)
  localparam logic [15:0] RST_LS_KP = 16'h003C;
  localparam logic [15:0] RST_LS_TI = 16'h0014;
  localparam logic [15:0] RST_HS_KP = 16'h001E;
  localparam logic [15:0] RST_HS_TI = 16'h0032;
  localparam logic [15:0] RST_SW_F1 = 16'h01F4;
  localparam logic [15:0] RST_SW_F2 = 16'h03E8;
  localparam logic [15:0] RST_LIM = 16'h0708;
  localparam logic [15:0] RST_CL_KP = 16'h07D0;
  localparam logic [15:0] RST_CL_KI = 16'h03E8;
  localparam logic [15:0] RST_OC_THR = 16'h05DC;
  localparam logic [15:0] RST_OC_GAIN = 16'h0032;
  localparam logic [15:0] RST_OC_COMP = 16'h0032;
  // accepted ranges
  localparam logic [15:0] KP_MIN = 16'h0001;
  localparam logic [15:0] KP_MAX = 16'h01F4;
  localparam logic [15:0] TI_MIN = 16'h0001;
  localparam logic [15:0] TI_MAX = 16'h01F4;
  localparam logic [15:0] LIM_MAX = 16'h0BB8;
  localparam logic [15:0] CL_MAX = 16'hEA60;
  localparam logic [15:0] OC_THR_MIN = 16'h01F4;
  localparam logic [15:0] OC_THR_MAX = 16'h07D0;
  localparam logic [15:0] OC_GAIN_MAX = 16'h0064;
  localparam logic [15:0] OC_COMP_MIN = 16'h0032;
  localparam logic [15:0] OC_COMP_MAX = 16'h00C8;
  // torque-limit source codes
  typedef enum logic [2:0] {
    SRC_DIGITAL = 3'b000,
    SRC_ANALOG = 3'b001,
    SRC_PANEL = 3'b100,
    SRC_COMM = 3'b101,
    SRC_PULSE = 3'b110
  } stq_src_t;
endpackage : stq_pkg

// [rtl/stq_ctrl.sv]
// stq_ctrl: parameter registers, speed-loop gain scheduling, torque-limit select,
// over-current stall frequency handling. assumes inputs synchronous to ref_clk.
//
// Notes on behaviour
// - low set below f1, high above f2
// - linear blend between f1 and f2
// - low kp default 60, range 1-500
// - low ti default 0.20 s, 0.01-5.00
// - high kp default 30, range 1-500
// - high ti default 0.50 s, 0.01-5.00
// - f1 default 5.00 Hz, 0 to f2
// - f2 default 10.00 Hz, f1 to max
// - motoring or generating limit source by state
// - motoring source codes 0,1,4,5,6, default 0
// - generating source same codes, default 0
// - motoring limit default 180.0%, 0-300%
// - generating limit default 180.0%, 0-300%
// - lock=1 uses motoring channel for generating; code takes mot_src_q but keeps gen_lim_q as the digital value
// - stall lowers frequency while current over threshold
// - ramp resumes once current drops below
// - stall threshold default 150.0%, 50-200%
// - stall gain default 50, range 0-100
// - high-speed comp default 50, range 50-200
// - pulse current limit enable, default on
// - current-loop kp default 2000, 0-60000
// - current-loop ki default 1000, 0-60000
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module stq_ctrl
  import stq_pkg::*;
(
  input wire logic ref_clk, // 250 MHz clock
  input wire logic rstn, // async reset, active low
  input wire logic [15:0] reg_addr, // register index
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire logic ctrl_tick, // control update pulse
  input wire logic [15:0] max_output_frequency, // max freq, 0.01 Hz
  input wire logic [15:0] target_freq, // target freq, 0.01 Hz
  input wire logic [15:0] freq_step, // ramp step per update
  input wire logic [15:0] out_current, // current, 0.1 % rated
  input wire logic motoring, // 1 motoring, 0 generating
  input wire logic [15:0] lim_analog, // analog input limit, 0.1 %
  input wire logic [15:0] lim_panel, // panel pot limit
  input wire logic [15:0] lim_comm, // communication limit
  input wire logic [15:0] lim_pulse, // pulse input limit
  output logic [15:0] sched_kp_q, // scheduled speed kp
  output logic [15:0] sched_ti_q, // scheduled speed ti
  output logic [15:0] torque_limit_q, // active torque limit, 0.1 %
  output logic [15:0] run_freq_q, // operating frequency
  output logic stall_active_q, // stall suppression acting
  output logic pulse_limit_en, // pulse-by-pulse limit enable
  output logic [15:0] ex_kp, // excitation kp
  output logic [15:0] ex_ki, // excitation ki
  output logic [15:0] tq_kp, // torque kp
  output logic [15:0] tq_ki // torque ki
);

  // parameter registers
  logic [15:0] ls_kp_q, ls_ti_q, hs_kp_q, hs_ti_q; // speed-loop sets
  logic [15:0] f1_q, f2_q; // switchover frequencies
  logic lock_q; // torque lock select
  logic [2:0] mot_src_q, gen_src_q; // limit sources
  logic [15:0] mot_lim_q, gen_lim_q; // digital limits
  logic [15:0] ex_kp_q, ex_ki_q, tq_kp_q, tq_ki_q; // current-loop gains
  logic oc_en_q, pcl_en_q; // enables
  logic [15:0] oc_thr_q, oc_gain_q, oc_comp_q; // stall settings

  // range check helper
  function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction : in_rng

  // legal source code check
  function automatic logic src_ok(input logic [15:0] v);
    src_ok = (v == 16'h0000) || (v == 16'h0001) || (v == 16'h0004) ||
             (v == 16'h0005) || (v == 16'h0006);
  endfunction : src_ok

  // register writes; out-of-range values are ignored
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ls_kp_q <= RST_LS_KP;
      ls_ti_q <= RST_LS_TI;
      hs_kp_q <= RST_HS_KP;
      hs_ti_q <= RST_HS_TI;
      f1_q <= RST_SW_F1;
      f2_q <= RST_SW_F2;
      lock_q <= 1'b0;
      mot_src_q <= SRC_DIGITAL;
      gen_src_q <= SRC_DIGITAL;
      mot_lim_q <= RST_LIM;
      gen_lim_q <= RST_LIM;
      ex_kp_q <= RST_CL_KP;
      tq_kp_q <= RST_CL_KP;
      ex_ki_q <= RST_CL_KI;
      tq_ki_q <= RST_CL_KI;
      oc_en_q <= 1'b1;
      oc_thr_q <= RST_OC_THR;
      oc_gain_q <= RST_OC_GAIN;
      oc_comp_q <= RST_OC_COMP;
      pcl_en_q <= 1'b1;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_LS_KP: if (in_rng(reg_wdata, KP_MIN, KP_MAX)) ls_kp_q <= reg_wdata;
        ADDR_LS_TI: if (in_rng(reg_wdata, TI_MIN, TI_MAX)) ls_ti_q <= reg_wdata;
        ADDR_HS_KP: if (in_rng(reg_wdata, KP_MIN, KP_MAX)) hs_kp_q <= reg_wdata;
        ADDR_HS_TI: if (in_rng(reg_wdata, TI_MIN, TI_MAX)) hs_ti_q <= reg_wdata;
        ADDR_SW_F1: if (reg_wdata <= f2_q) f1_q <= reg_wdata;
        ADDR_SW_F2: if (in_rng(reg_wdata, f1_q, max_output_frequency)) f2_q <= reg_wdata;
        ADDR_LOCK: if (reg_wdata <= 16'h0001) lock_q <= reg_wdata[0];
        ADDR_MOT_SRC: if (src_ok(reg_wdata)) mot_src_q <= reg_wdata[2:0];
        ADDR_GEN_SRC: if (src_ok(reg_wdata)) gen_src_q <= reg_wdata[2:0];
        ADDR_MOT_LIM: if (reg_wdata <= LIM_MAX) mot_lim_q <= reg_wdata;
        ADDR_GEN_LIM: if (reg_wdata <= LIM_MAX) gen_lim_q <= reg_wdata;
        ADDR_EX_KP: if (reg_wdata <= CL_MAX) ex_kp_q <= reg_wdata;
        ADDR_EX_KI: if (reg_wdata <= CL_MAX) ex_ki_q <= reg_wdata;
        ADDR_TQ_KP: if (reg_wdata <= CL_MAX) tq_kp_q <= reg_wdata;
        ADDR_TQ_KI: if (reg_wdata <= CL_MAX) tq_ki_q <= reg_wdata;
        ADDR_OC_EN: if (reg_wdata <= 16'h0001) oc_en_q <= reg_wdata[0];
        ADDR_OC_THR: if (in_rng(reg_wdata, OC_THR_MIN, OC_THR_MAX)) oc_thr_q <= reg_wdata;
        ADDR_OC_GAIN: if (reg_wdata <= OC_GAIN_MAX) oc_gain_q <= reg_wdata;
        ADDR_OC_COMP: if (in_rng(reg_wdata, OC_COMP_MIN, OC_COMP_MAX)) oc_comp_q <= reg_wdata;
        ADDR_PCL_EN: if (reg_wdata <= 16'h0001) pcl_en_q <= reg_wdata[0];
        default: ; // unmapped write ignored
      endcase
    end
  end

  // read mux, data one cycle after strobe, zero elsewhere
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else if (!reg_rd)
      reg_rdata <= 16'h0000;
    else
    begin
      unique case (reg_addr)
        ADDR_LS_KP: reg_rdata <= ls_kp_q;
        ADDR_LS_TI: reg_rdata <= ls_ti_q;
        ADDR_HS_KP: reg_rdata <= hs_kp_q;
        ADDR_HS_TI: reg_rdata <= hs_ti_q;
        ADDR_SW_F1: reg_rdata <= f1_q;
        ADDR_SW_F2: reg_rdata <= f2_q;
        ADDR_LOCK: reg_rdata <= {15'h0000, lock_q};
        ADDR_MOT_SRC: reg_rdata <= {13'h0000, mot_src_q};
        ADDR_GEN_SRC: reg_rdata <= {13'h0000, gen_src_q};
        ADDR_MOT_LIM: reg_rdata <= mot_lim_q;
        ADDR_GEN_LIM: reg_rdata <= gen_lim_q;
        ADDR_EX_KP: reg_rdata <= ex_kp_q;
        ADDR_EX_KI: reg_rdata <= ex_ki_q;
        ADDR_TQ_KP: reg_rdata <= tq_kp_q;
        ADDR_TQ_KI: reg_rdata <= tq_ki_q;
        ADDR_OC_EN: reg_rdata <= {15'h0000, oc_en_q};
        ADDR_OC_THR: reg_rdata <= oc_thr_q;
        ADDR_OC_GAIN: reg_rdata <= oc_gain_q;
        ADDR_OC_COMP: reg_rdata <= oc_comp_q;
        ADDR_PCL_EN: reg_rdata <= {15'h0000, pcl_en_q};
        ADDR_STATUS: reg_rdata <= {15'h0000, stall_active_q};
        default: reg_rdata <= 16'h0000; // unmapped reads zero
      endcase
    end
  end

  // current-loop gains and pulse limit straight from registers
  assign ex_kp = ex_kp_q;
  assign ex_ki = ex_ki_q;
  assign tq_kp = tq_kp_q;
  assign tq_ki = tq_ki_q;
  assign pulse_limit_en = pcl_en_q;

  // gain blend: low + (high-low)*(f-f1)/(f2-f1)
  logic [15:0] span; // f2 - f1
  logic [15:0] pos; // f - f1
  logic signed [17:0] dkp, dti; // set differences
  logic signed [34:0] pkp, pti; // products
  logic [15:0] kp_d, ti_d; // scheduled next values
  always_comb
  begin
    span = f2_q - f1_q;
    pos = run_freq_q - f1_q;
    dkp = $signed({2'b00, hs_kp_q}) - $signed({2'b00, ls_kp_q});
    dti = $signed({2'b00, hs_ti_q}) - $signed({2'b00, ls_ti_q});
    pkp = dkp * $signed({1'b0, pos});
    pti = dti * $signed({1'b0, pos});
    if (run_freq_q <= f1_q)
    begin
      kp_d = ls_kp_q;
      ti_d = ls_ti_q;
    end
    else if (run_freq_q >= f2_q)
    begin
      kp_d = hs_kp_q;
      ti_d = hs_ti_q;
    end
    else
    begin
      kp_d = 16'(ls_kp_q + 16'(pkp / $signed({19'h00000, span})));
      ti_d = 16'(ls_ti_q + 16'(pti / $signed({19'h00000, span})));
    end
  end

  // schedule latched on each control update from present frequency
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sched_kp_q <= RST_LS_KP;
      sched_ti_q <= RST_LS_TI;
    end
    else if (ctrl_tick)
    begin
      sched_kp_q <= kp_d;
      sched_ti_q <= ti_d;
    end
  end

  // source decode to a limit value
  function automatic logic [15:0] pick(input logic [2:0] s, input logic [15:0] dig);
    unique case (s)
      SRC_ANALOG: pick = lim_analog;
      SRC_PANEL: pick = lim_panel;
      SRC_COMM: pick = lim_comm;
      SRC_PULSE: pick = lim_pulse;
      default: pick = dig; // digital setting
    endcase
  endfunction : pick

  // torque limit by drive state, lock forces motoring source code, digital value stays gen_lim_q
  logic [2:0] gen_eff; // generating channel in use
  assign gen_eff = lock_q ? mot_src_q : gen_src_q;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      torque_limit_q <= RST_LIM;
    else if (motoring)
      torque_limit_q <= pick(mot_src_q, mot_lim_q);
    else
      torque_limit_q <= pick(gen_eff, gen_lim_q);
  end

  // stall threshold reduced at high speed by comp * f / fmax / 10
  logic [31:0] red; // reduction in 0.1 %
  logic [15:0] thr_eff; // effective threshold
  always_comb
  begin
    red = (32'(oc_comp_q) * 32'(run_freq_q)) /
          (32'(max_output_frequency) * 32'h0000000A + 32'h00000001);
    if (run_freq_q > f2_q && red < 32'(oc_thr_q))
      thr_eff = oc_thr_q - red[15:0];
    else
      thr_eff = oc_thr_q;
  end

  // frequency ramp with over-current stall suppression
  logic over; // current above effective threshold
  logic [15:0] dec; // frequency drop per update
  assign over = oc_en_q && (out_current > thr_eff);
  assign dec = 16'((32'(oc_gain_q) * 32'(freq_step) + 32'h00000031) / 32'h00000032);
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      run_freq_q <= 16'h0000;
      stall_active_q <= 1'b0;
    end
    else if (ctrl_tick)
    begin
      stall_active_q <= over;
      if (over)
        run_freq_q <= (run_freq_q > dec) ? run_freq_q - dec : 16'h0000;
      else if (run_freq_q < target_freq)
        run_freq_q <= (target_freq - run_freq_q > freq_step) ?
                      run_freq_q + freq_step : target_freq;
      else if (run_freq_q > target_freq)
        run_freq_q <= (run_freq_q - target_freq > freq_step) ?
                      run_freq_q - freq_step : target_freq;
    end
  end

  // assertions
  property p_low_set;
    @(posedge ref_clk) disable iff (!rstn)
      (ctrl_tick && run_freq_q <= f1_q) |=> (sched_kp_q == $past(ls_kp_q));
  endproperty
  a_low_set: assert property (p_low_set) else $error("low kp not used");

  property p_high_set;
    @(posedge ref_clk) disable iff (!rstn)
      (ctrl_tick && run_freq_q >= f2_q && f2_q > f1_q) |=> (sched_ti_q == $past(hs_ti_q));
  endproperty
  a_high_set: assert property (p_high_set) else $error("high ti not used");

  property p_blend;
    @(posedge ref_clk) disable iff (!rstn)
      (ctrl_tick && run_freq_q > f1_q && run_freq_q < f2_q)
      |=> ((sched_kp_q >= $past(ls_kp_q) && sched_kp_q <= $past(hs_kp_q)) ||
           (sched_kp_q <= $past(ls_kp_q) && sched_kp_q >= $past(hs_kp_q)));
  endproperty
  a_blend: assert property (p_blend) else $error("blend out of bounds");

  property p_lim_mot;
    @(posedge ref_clk) disable iff (!rstn)
      (motoring && mot_src_q == SRC_DIGITAL) |=> (torque_limit_q == $past(mot_lim_q));
  endproperty
  a_lim_mot: assert property (p_lim_mot) else $error("motoring limit wrong");

  property p_lock;
    @(posedge ref_clk) disable iff (!rstn)
      (!motoring && lock_q && mot_src_q == SRC_COMM) |=> (torque_limit_q == $past(lim_comm));
  endproperty
  a_lock: assert property (p_lock) else $error("lock channel wrong");

  property p_stall;
    @(posedge ref_clk) disable iff (!rstn)
      (ctrl_tick && over && run_freq_q != 16'h0000) |=> (run_freq_q < $past(run_freq_q));
  endproperty
  a_stall: assert property (p_stall) else $error("stall did not lower freq");

  property p_resume;
    @(posedge ref_clk) disable iff (!rstn)
      (ctrl_tick && !over && run_freq_q < target_freq) |=> (run_freq_q > $past(run_freq_q));
  endproperty
  a_resume: assert property (p_resume) else $error("ramp did not resume");

  property p_range;
    @(posedge ref_clk) disable iff (!rstn)
      ##1 (f1_q <= f2_q && ls_kp_q >= KP_MIN && oc_thr_q >= OC_THR_MIN && mot_lim_q <= LIM_MAX);
  endproperty
  a_range: assert property (p_range) else $error("parameter out of range");

  property p_pcl;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_wr && reg_addr == ADDR_PCL_EN && reg_wdata == 16'h0000) |=> !pulse_limit_en;
  endproperty
  a_pcl: assert property (p_pcl) else $error("pulse limit not disabled");

endmodule : stq_ctrl

// [verification/stq_tb.sv]
// stq_tb: self-checking bench for the drive parameter block stq_ctrl.
// assumes the register port answers a read in the cycle after the strobe.
`timescale 1ns/1ps
module tb
  import stq_pkg::*;
;
  logic ref_clk; // 4 ns clock
  logic rstn; // active low reset
  logic [15:0] reg_addr; // register index
  logic [15:0] reg_wdata; // write data
  logic reg_wr; // write strobe
  logic reg_rd; // read strobe
  logic [15:0] reg_rdata; // read data
  logic ctrl_tick; // control update pulse
  logic [15:0] max_output_frequency; // max frequency
  logic [15:0] target_freq; // ramp target
  logic [15:0] freq_step; // ramp step
  logic [15:0] out_current; // measured current
  logic motoring; // motoring state
  logic [15:0] lim_analog, lim_panel, lim_comm, lim_pulse; // external limit sources
  logic [15:0] sched_kp_q, sched_ti_q, torque_limit_q, run_freq_q; // scheduled outputs
  logic stall_active_q; // stall flag
  logic pulse_limit_en; // pulse limit enable
  logic [15:0] ex_kp, ex_ki, tq_kp, tq_ki; // current-loop gains
  logic [15:0] rd; // last read value
  int num_errors = 0; // mismatch count
  int total_checks = 0; // comparison count
  // register map and reset values, walked in one loop
  localparam logic [15:0] RA [20] = '{ADDR_LS_KP, ADDR_LS_TI, ADDR_HS_KP, ADDR_HS_TI,
    ADDR_SW_F1, ADDR_SW_F2, ADDR_LOCK, ADDR_MOT_SRC, ADDR_MOT_LIM, ADDR_GEN_SRC,
    ADDR_GEN_LIM, ADDR_EX_KP, ADDR_EX_KI, ADDR_TQ_KP, ADDR_TQ_KI, ADDR_OC_EN,
    ADDR_OC_THR, ADDR_OC_GAIN, ADDR_OC_COMP, ADDR_PCL_EN};
  localparam logic [15:0] RV [20] = '{16'h003C, 16'h0014, 16'h001E, 16'h0032, 16'h01F4,
    16'h03E8, 16'h0000, 16'h0000, 16'h0708, 16'h0000, 16'h0708, 16'h07D0, 16'h03E8,
    16'h07D0, 16'h03E8, 16'h0001, 16'h05DC, 16'h0032, 16'h0032, 16'h0001};
  // out-of-range writes: index into RA, refused value
  localparam int BI [16] = '{0, 0, 1, 3, 4, 5, 7, 9, 8, 10, 11, 14, 16, 16, 17, 18};
  localparam logic [15:0] BV [16] = '{16'h0000, 16'h01F5, 16'h0000, 16'h01F5, 16'h03E9,
    16'h01F3, 16'h0002, 16'h0007, 16'h0BB9, 16'h0BB9, 16'hEA61, 16'hEA61, 16'h01F3, 16'h07D1,
    16'h0065, 16'h0031};

  stq_ctrl uut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ctrl_tick(ctrl_tick), .max_output_frequency(max_output_frequency),
    .target_freq(target_freq), .freq_step(freq_step), .out_current(out_current),
    .motoring(motoring), .lim_analog(lim_analog), .lim_panel(lim_panel),
    .lim_comm(lim_comm), .lim_pulse(lim_pulse), .sched_kp_q(sched_kp_q),
    .sched_ti_q(sched_ti_q), .torque_limit_q(torque_limit_q), .run_freq_q(run_freq_q),
    .stall_active_q(stall_active_q), .pulse_limit_en(pulse_limit_en), .ex_kp(ex_kp),
    .ex_ki(ex_ki), .tq_kp(tq_kp), .tq_ki(tq_ki));

  // free-running clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // compare one value, report and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
    chk(rd, exp);
  endtask : rdc

  // one control update, outputs settle at the next edge
  task automatic tick(input logic [15:0] tgt, input logic [15:0] stp);
    @(posedge ref_clk);
    target_freq <= tgt;
    freq_step <= stp;
    ctrl_tick <= 1'b1;
    @(posedge ref_clk);
    ctrl_tick <= 1'b0;
    #1;
  endtask : tick

  // let the limit mux settle for three cycles
  task automatic lim(input logic [15:0] exp);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(torque_limit_q, exp);
  endtask : lim

  // verdict and end of run
  task automatic tally_and_finish();
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // watchdog against a hung run
  initial
  begin
    #40000;
    num_errors++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    rstn = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ctrl_tick = 1'b0;
    max_output_frequency = 16'h1388;
    target_freq = 16'h0000;
    freq_step = 16'h0000;
    out_current = 16'h03E8;
    motoring = 1'b1;
    lim_analog = 16'h0111;
    lim_panel = 16'h0222;
    lim_comm = 16'h0333;
    lim_pulse = 16'h0044;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    // reset state of outputs and registers
    #1;
    chk(sched_kp_q, 16'h003C);
    chk(sched_ti_q, 16'h0014);
    chk(torque_limit_q, 16'h0708);
    chk({15'h0000, pulse_limit_en}, 16'h0001);
    chk(tq_ki, 16'h03E8);
    chk(ex_ki, 16'h03E8);
    chk(tq_kp, 16'h07D0);
    for (int i = 0; i < 20; i++) rdc(RA[i], RV[i]);
    rdc(16'h0F00, 16'h0000); // unmapped read gives zero
    // refused writes leave the reset value
    for (int i = 0; i < 16; i++)
    begin
      wr(RA[BI[i]], BV[i]);
      rdc(RA[BI[i]], RV[BI[i]]);
    end
    // boundary writes accepted
    wr(ADDR_EX_KP, 16'hEA60);
    rdc(ADDR_EX_KP, 16'hEA60);
    chk(ex_kp, 16'hEA60);
    wr(ADDR_TQ_KI, 16'h0000);
    #1;
    chk(tq_ki, 16'h0000);
    wr(ADDR_OC_COMP, 16'h00C8);
    rdc(ADDR_OC_COMP, 16'h00C8);
    wr(ADDR_PCL_EN, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk({15'h0000, pulse_limit_en}, 16'h0000);
    // gain scheduling: below f1, above f2, halfway between
    tick(16'h012C, 16'h012C);
    tick(16'h012C, 16'h0000);
    chk(sched_kp_q, 16'h003C);
    tick(16'h04B0, 16'h0384);
    tick(16'h04B0, 16'h0000);
    chk(sched_kp_q, 16'h001E);
    chk(sched_ti_q, 16'h0032);
    tick(16'h02EE, 16'h01C2);
    tick(16'h02EE, 16'h0000);
    chk(run_freq_q, 16'h02EE);
    chk(sched_kp_q, 16'h002D);
    chk(sched_ti_q, 16'h0023);
    // moving f1 up to the running point switches to the low set
    wr(ADDR_SW_F1, 16'h02EE);
    tick(16'h02EE, 16'h0000);
    chk(sched_kp_q, 16'h003C);
    // over-current stall lowers frequency, then ramp resumes
    out_current <= 16'h0640;
    tick(16'h02EE, 16'h0064);
    chk(run_freq_q, 16'h028A);
    chk({15'h0000, stall_active_q}, 16'h0001);
    rdc(ADDR_STATUS, 16'h0001);
    out_current <= 16'h03E8;
    tick(16'h02EE, 16'h0064);
    chk(run_freq_q, 16'h02EE);
    chk({15'h0000, stall_active_q}, 16'h0000);
    // at full speed the comp of 200 pulls the threshold below 149.0 %
    out_current <= 16'h05D2;
    tick(16'h1388, 16'h1388);
    chk(run_freq_q, 16'h1388);
    tick(16'h1388, 16'h0064);
    chk(run_freq_q, 16'h1324);
    chk({15'h0000, stall_active_q}, 16'h0001);
    out_current <= 16'h03E8;
    tick(16'h02EE, 16'h1388);
    chk(run_freq_q, 16'h02EE);
    wr(ADDR_OC_EN, 16'h0000);
    out_current <= 16'h0640;
    tick(16'h02EE, 16'h0064);
    chk(run_freq_q, 16'h02EE);
    out_current <= 16'h03E8;
    // torque limit sources, full scale set to 100.0 %
    wr(ADDR_MOT_LIM, 16'h03E8);
    lim(16'h03E8);
    wr(ADDR_MOT_SRC, 16'h0001);
    lim(lim_analog);
    wr(ADDR_MOT_SRC, 16'h0004);
    lim(lim_panel);
    wr(ADDR_MOT_SRC, 16'h0005);
    lim(lim_comm);
    wr(ADDR_MOT_SRC, 16'h0006);
    lim(lim_pulse);
    motoring <= 1'b0;
    lim(16'h0708);
    wr(ADDR_GEN_LIM, 16'h03E8);
    wr(ADDR_GEN_SRC, 16'h0001);
    lim(lim_analog);
    wr(ADDR_MOT_SRC, 16'h0005);
    wr(ADDR_LOCK, 16'h0001);
    lim(lim_comm);
    wr(ADDR_LOCK, 16'h0000);
    lim(lim_analog);
    tally_and_finish();
  end
endmodule : tb
